// *** spih_pkg.sv ***
// package: register map, field layout, timing and pad types of the spi partner
package spih_pkg;

    // ==========================================================
    // register offsets on the plain software port
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_TX = 2'h2;
    localparam logic [1:0] ADDR_RX = 2'h3;

    // ==========================================================
    // control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_POLARITY = 2;
    localparam int CTRL_PHASE = 3;
    localparam int CTRL_HOLD = 4;
    localparam int CTRL_DIV_LSB = 8;
    localparam int DIV_WIDTH = 8;
    localparam logic [7:0] DIV_RESET = 8'h08;

    // ==========================================================
    // status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_OVERRUN = 2;
    localparam int STAT_COLLISION = 3;

    // ==========================================================
    // timing: own clock, device cpu clock, select gap between bytes
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEV_CPU_PERIOD_NS = 125;
    localparam int MIN_HALF_CYC =
        (DEV_CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_GAP_NS = 250;
    localparam int SEL_GAP_CYC =
        (SEL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // types
    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
        logic miso;
    } spih_pad_t;

    typedef struct packed {
        logic enable;
        logic master;
        logic polarity;
        logic phase;
        logic hold_select;
        logic [DIV_WIDTH-1:0] half_div;
    } spih_cfg_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_LEAD,
        S_SHIFT,
        S_TAIL,
        S_GAP
    } spih_state_t;

endpackage : spih_pkg

// *** spih_sync.sv ***
// two-flop synchroniser for the pad inputs
`timescale 1ns/10ps
module spih_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // ==========================================================
    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : spih_sync

// *** spih_ctrl.sv ***
// spi partner controller: master or slave end facing the serial port
//
// Behaviour
// - only the master starts; each byte is full duplex on one clock
// - external master must not clock the device above cpu/2
// - device master's internal select must stay high throughout
// - phase set: select stays low for the whole transmission; here only with hold_select set, else high between bytes
// - phase clear: select low per byte, high between bytes
// - enable master only after rate, polarity, phase, select set
// - done must be cleared before next byte ends, else overrun
// - enable slave only after polarity, phase, select are set
// - polarity and phase pick four modes; both ends must match
// - disable before changing clock polarity between bytes
`timescale 1ns/10ps
module spih_ctrl
    import spih_pkg::*;
#(
    parameter int GAP_CYCLES = SEL_GAP_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire spih_pad_t pad_in,
    output spih_pad_t pad_out,
    output spih_pad_t pad_oe
);

    // ==========================================================
    // elaboration checks
    if (GAP_CYCLES < 1 || GAP_CYCLES > 255)
    begin : g_bad_gap
        $error("GAP_CYCLES must lie between 1 and 255");
    end
    if (MIN_HALF_CYC < 1 || MIN_HALF_CYC > 255)
    begin : g_bad_half
        $error("MIN_HALF_CYC must lie between 1 and 255");
    end

    localparam logic [7:0] MIN_HALF = 8'(MIN_HALF_CYC);
    localparam logic [7:0] GAP_LAST = 8'(GAP_CYCLES - 1);

    spih_cfg_t cfg;
    spih_state_t state;
    spih_state_t next_state;
    spih_pad_t pad_s;
    spih_pad_t next_pad_out;
    spih_pad_t next_pad_oe;
    logic [7:0] cnt;
    logic [3:0] edge_cnt;
    logic [2:0] bits;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic out_bit;
    logic next_out_bit;
    logic sck_prev;
    logic done_flag;
    logic ovr_flag;
    logic write_collision_flag_flag;

    // ==========================================================
    // pad inputs cross into the clock domain
    spih_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(pad_in),
        .q(pad_s)
    );

    // ==========================================================
    // software port decode
    wire wr_ctrl = wr && (addr == ADDR_CTRL);
    wire wr_tx = wr && (addr == ADDR_TX);
    wire rd_status = rd && (addr == ADDR_STATUS);
    wire rd_rx = rd && (addr == ADDR_RX);

    // ==========================================================
    // mode and timing selection
    wire master_on = cfg.enable & cfg.master;
    wire slave_on = cfg.enable & ~cfg.master;
    wire [7:0] half_eff = (cfg.half_div < MIN_HALF) ? MIN_HALF
                                                    : cfg.half_div;
    wire half_tick = (cnt == half_eff - 8'h01);
    wire gap_done = (cnt == GAP_LAST);
    wire hold_low = cfg.hold_select & cfg.phase;

    // ==========================================================
    // master shift events: even edge is the leading one
    wire m_edge = (state == S_SHIFT) && half_tick;
    wire m_lead = ~edge_cnt[0];
    wire m_sample = m_edge & (m_lead == ~cfg.phase);
    wire m_shift = m_edge & ~m_sample;

    // ==========================================================
    // slave shift events from the synchronised device clock
    wire selected = slave_on & ~pad_s.ss_n;
    wire sck_change = pad_s.sck != sck_prev;
    wire s_lead = sck_change & (sck_prev == cfg.polarity);
    wire s_trail = sck_change & (sck_prev != cfg.polarity);
    wire s_sample = selected & (cfg.phase ? s_trail : s_lead);
    wire s_shift = selected & (cfg.phase ? s_lead : s_trail);

    // ==========================================================
    // merged shifter controls
    wire do_sample = m_sample | s_sample;
    wire do_shift = m_shift | s_shift;
    wire data_in = cfg.master ? pad_s.miso : pad_s.mosi;
    wire slave_busy = selected & (bits != 3'h0);
    wire busy = (state != S_IDLE) | slave_busy;
    wire byte_done = do_sample & (bits == 3'h7);
    wire start = wr_tx & master_on & (state == S_IDLE);
    wire slave_load = wr_tx & slave_on & ~slave_busy;
    wire collide = wr_tx & busy;
    wire load = start | slave_load;

    // ==========================================================
    // master sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:
                if (start)
                    next_state = S_LEAD;
            S_LEAD:
                if (half_tick)
                    next_state = S_SHIFT;
            S_SHIFT:
                if (half_tick && edge_cnt == 4'hF)
                    next_state = S_TAIL;
            S_TAIL:
                if (half_tick)
                    next_state = hold_low ? S_IDLE : S_GAP;
            S_GAP:
                if (gap_done)
                    next_state = S_IDLE;
            default:
                next_state = S_IDLE;
        endcase
        if (!master_on)
            next_state = S_IDLE;
    end

    // ==========================================================
    // sequencer state and half-period counter
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state <= S_IDLE;
            cnt <= 8'h00;
        end
        else
        begin
            state <= next_state;
            // the gap counts on past a half period, so no wrap in S_GAP
            cnt <= (next_state != state || (half_tick && state != S_GAP))
                   ? 8'h00 : cnt + 8'h01;
        end
    end

    // ==========================================================
    // clock edge and bit counters
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            edge_cnt <= 4'h0;
            bits <= 3'h0;
            sck_prev <= 1'b0;
        end
        else
        begin
            sck_prev <= pad_s.sck;
            if (state == S_IDLE)
                edge_cnt <= 4'h0;
            else if (m_edge)
                edge_cnt <= edge_cnt + 4'h1;
            if (load || (slave_on && pad_s.ss_n) || !cfg.enable)
                bits <= 3'h0;
            else if (do_sample)
                bits <= bits + 3'h1;
        end
    end

    // ==========================================================
    // shift registers, msb first in both directions
    always_comb
    begin
        next_out_bit = out_bit;
        if (load)
            next_out_bit = wdata[7];
        else if (do_shift)
            next_out_bit = cfg.phase ? tx_sh[7] : tx_sh[6];
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
            out_bit <= 1'b0;
        end
        else
        begin
            out_bit <= next_out_bit;
            if (load)
                tx_sh <= wdata[7:0];
            else if (do_shift)
                tx_sh <= {tx_sh[6:0], 1'b0};
            if (do_sample)
                rx_sh <= {rx_sh[6:0], data_in};
        end
    end

    // ==========================================================
    // received byte and sticky flags; a set beats a clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_data <= 8'h00;
            done_flag <= 1'b0;
            ovr_flag <= 1'b0;
            write_collision_flag_flag <= 1'b0;
        end
        else
        begin
            if (byte_done && !done_flag)
                rx_data <= {rx_sh[6:0], data_in};
            done_flag <= byte_done | (done_flag & ~rd_rx);
            ovr_flag <= (byte_done & done_flag)
                        | (ovr_flag & ~rd_status);
            write_collision_flag_flag <= collide | (write_collision_flag_flag & ~rd_status);
        end
    end

    // ==========================================================
    // configuration: fields change only while disabled
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cfg <= '{enable: 1'b0, master: 1'b0, polarity: 1'b0,
                     phase: 1'b0, hold_select: 1'b0,
                     half_div: DIV_RESET};
        end
        else if (wr_ctrl && !busy)
        begin
            cfg.enable <= wdata[CTRL_ENABLE];
            if (!cfg.enable)
            begin
                cfg.master <= wdata[CTRL_MASTER];
                cfg.polarity <= wdata[CTRL_POLARITY];
                cfg.phase <= wdata[CTRL_PHASE];
                cfg.hold_select <= wdata[CTRL_HOLD];
                cfg.half_div <= wdata[CTRL_DIV_LSB +: DIV_WIDTH];
            end
        end
        else if (wr_ctrl && !wdata[CTRL_ENABLE])
        begin
            cfg.enable <= 1'b0;
        end
    end

    // ==========================================================
    // pad drive: clock, select, data and their enables
    always_comb
    begin
        next_pad_out = pad_out;
        next_pad_out.mosi = next_out_bit;
        next_pad_out.miso = next_out_bit;
        if (state == S_IDLE || next_state == S_IDLE)
            next_pad_out.sck = cfg.polarity;
        else if (m_edge)
            next_pad_out.sck = ~pad_out.sck;
        if (!master_on)
            next_pad_out.ss_n = 1'b1;
        else if (start)
            next_pad_out.ss_n = 1'b0;
        else if (state == S_TAIL && half_tick && !hold_low)
            next_pad_out.ss_n = 1'b1;
        else if (state == S_IDLE && !hold_low)
            next_pad_out.ss_n = 1'b1;
        next_pad_oe.sck = master_on;
        next_pad_oe.ss_n = cfg.enable;
        next_pad_oe.mosi = master_on;
        next_pad_oe.miso = selected;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pad_out <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
            pad_oe <= '0;
        end
        else
        begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
        end
    end

    // ==========================================================
    // read data, one cycle after the strobe, zero otherwise
    wire [15:0] ctrl_view = {cfg.half_div, 3'h0, cfg.hold_select,
                             cfg.phase, cfg.polarity, cfg.master,
                             cfg.enable};
    wire [15:0] status_view = {12'h000, write_collision_flag_flag, ovr_flag, done_flag,
                               busy};
    wire [15:0] read_mux = (addr == ADDR_CTRL) ? ctrl_view :
                           (addr == ADDR_STATUS) ? status_view :
                           (addr == ADDR_TX) ? {8'h00, tx_sh} :
                           {8'h00, rx_data};

    always_ff @(posedge clk)
    begin
        if (!resetn)
            rdata <= 16'h0000;
        else
            rdata <= rd ? read_mux : 16'h0000;
    end

endmodule : spih_ctrl

// *** spih_ctrl_props.sv ***
// checker: serial pad timing of the spi controller
`timescale 1ns/10ps
module spih_ctrl_props
    import spih_pkg::*;
#(
    parameter int GAP_CYCLES = SEL_GAP_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire spih_pad_t pad_in,
    input wire spih_pad_t pad_out,
    input wire spih_pad_t pad_oe
);
    logic sck_q;
    logic [5:0] tgl_cnt;
    logic [7:0] hi_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ==========================================================
    // helpers: clock toggles inside a frame, cycles deselected
    always_ff @(posedge clk)
    begin
        sck_q <= pad_out.sck;
        tgl_cnt <= (!resetn || pad_out.ss_n) ? 6'h00 :
            tgl_cnt + {5'h00, pad_out.sck ^ sck_q};
        hi_cnt <= !resetn ? 8'hFF : !pad_out.ss_n ? 8'h00 :
            hi_cnt + {7'h00, ~&hi_cnt};
    end
    // ==========================================================
    // pad relations while the controller drives the link
    sck_in_frame_a: assert property (
        $changed(pad_out.sck) && pad_oe.sck && $past(pad_oe.sck)
        |-> !pad_out.ss_n && !$past(pad_out.ss_n))
        else $error("serial clock moved outside a frame");
    half_period_a: assert property (
        $changed(pad_out.sck) && pad_oe.sck |=> $stable(pad_out.sck) [*4])
        else $error("serial clock half period too short");
    lead_time_a: assert property (
        $fell(pad_out.ss_n) |-> $stable(pad_out.sck) [*5])
        else $error("clock edge too soon after select");
    mosi_edge_a: assert property (
        pad_oe.mosi && !pad_out.ss_n && !$fell(pad_out.ss_n)
        && $changed(pad_out.mosi) |-> $changed(pad_out.sck) || $past(wr))
        else $error("data out changed away from a clock edge");
    frame_bits_a: assert property (
        $rose(pad_out.ss_n) && pad_oe.ss_n
        |-> tgl_cnt != 6'h00 && tgl_cnt[3:0] == 4'h0)
        else $error("frame did not hold whole bytes");
    ss_gap_a: assert property (
        $fell(pad_out.ss_n) |-> hi_cnt >= GAP_CYCLES)
        else $error("select high gap too short");
    drive_pair_a: assert property (
        pad_oe.sck == pad_oe.mosi && !(pad_oe.miso && pad_oe.sck))
        else $error("master and slave drives overlap");
    dev_sel_high_a: assert property (
        pad_oe.miso |-> pad_oe.ss_n && pad_out.ss_n)
        else $error("device select not held high in slave mode");
    miso_sel_a: assert property (
        $rose(pad_oe.miso) |-> !pad_in.ss_n && !$past(pad_in.ss_n, 2))
        else $error("slave out driven without select");
    // main scenarios
    cover property ($fell(pad_out.ss_n));
    cover property ($rose(pad_oe.miso));
    cover property (pad_oe.sck && pad_out.sck && !pad_out.ss_n);
endmodule : spih_ctrl_props

bind spih_ctrl spih_ctrl_props #(
    .GAP_CYCLES(GAP_CYCLES)
) u_props (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe)
);

// *** spih_dev_model.sv ***
// device model: serial port in slave mode facing the controller
`timescale 1ns/10ps
module spih_dev_model (
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic [7:0] tx_byte,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] rx_byte,
    output int n_bytes
);
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    initial
    begin
        miso = 1'b0;
        rx_byte = 8'h00;
        n_bytes = 0;
    end
    // select low loads the byte; phase clear shows the msb at once
    always @(negedge ss_n)
    begin
        sh = tx_byte;
        cnt = 0;
        if (!clock_phase)
            miso = sh[7];
    end
    // a released line shows the inverse of its last level
    always @(posedge ss_n)
        miso = ~miso;
    // sampling edge shifts in, the other edge drives the next bit
    always @(sck)
    begin
        if (!ss_n && ((sck != clock_polarity) != clock_phase))
        begin
            sh = {sh[6:0], mosi};
            cnt = cnt + 1;
            if (cnt == 8)
            begin
                rx_byte = sh;
                n_bytes = n_bytes + 1;
                cnt = 0;
            end
        end
        else if (!ss_n)
        begin
            if (clock_phase && cnt == 0)
                sh = tx_byte;
            miso = sh[7];
        end
    end
endmodule : spih_dev_model

// *** spih_ctrl_tb.sv ***
// testbench: spi controller against a device model and a bench master
`timescale 1ns/10ps
module spih_ctrl_tb
    import spih_pkg::*;
();
    localparam int GAP = 2;
    logic clk;
    logic resetn;
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    spih_pad_t pin;
    spih_pad_t pout;
    spih_pad_t poe;
    logic m_sck;
    logic m_ss;
    logic m_mosi;
    logic cur_pol;
    logic cur_pha;
    logic dev_miso;
    logic [7:0] dev_tx;
    logic [7:0] dev_rx;
    int dev_n;
    int miscompares = 0;
    int n_compared = 0;
    int exp_q[$];
    int h;
    logic [7:0] b;
    logic [7:0] got;
    // ==========================================================
    // wire levels: clock and data from whoever enables, else bench or device; select always from the bench
    assign pin = {poe.sck ? pout.sck : m_sck, m_ss,
        poe.mosi ? pout.mosi : m_mosi, poe.miso ? pout.miso : dev_miso};
    spih_ctrl #(
        .GAP_CYCLES(GAP)
    ) u_dut (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pad_in(pin), .pad_out(pout),
        .pad_oe(poe)
    );
    spih_dev_model u_dev (
        .clock_polarity(cur_pol), .clock_phase(cur_pha), .tx_byte(dev_tx), .sck(pin.sck),
        .ss_n(poe.ss_n ? pout.ss_n : 1'b1), .mosi(pin.mosi),
        .miso(dev_miso), .rx_byte(dev_rx), .n_bytes(dev_n)
    );
    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // bus and comparison tasks
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_rd(input logic [1:0] a, input logic [15:0] e,
        input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask : chk_rd
    // disable, set fields, then enable with the same fields
    task automatic set_cfg(input logic pol, input logic ph,
        input logic mst, input logic hold, input int hd);
        logic [15:0] c;
        c = {hd[7:0], 3'h0, hold, ph, pol, mst, 1'b0};
        cur_pol = pol;
        cur_pha = ph;
        m_sck <= pol;
        wr_reg(ADDR_CTRL, 16'h0000);
        wr_reg(ADDR_CTRL, c);
        wr_reg(ADDR_CTRL, c | 16'h0001);
        chk_rd(ADDR_CTRL, c | 16'h0001, "ctrl");
    endtask : set_cfg
    // one master byte; the device answers with a random byte
    task automatic send(input int hd, input bit coll, input bit hold);
        int t;
        b = 8'($urandom_range(255));
        dev_tx = 8'($urandom_range(255));
        exp_q.push_back(int'(dev_tx));
        t = dev_n + 1;
        wr_reg(ADDR_TX, {8'h00, b});
        if (coll)
            wr_reg(ADDR_TX, {8'h00, ~b});
        for (int i = 0; i < 5000 && dev_n < t; i++)
            @(posedge clk);
        if (dev_n < t)
        begin
            miscompares++;
            report_and_stop();
        end
        chk("device rx", {8'h00, b}, {8'h00, dev_rx});
        repeat (3 * (hd < 5 ? 5 : hd) + GAP + 4) @(posedge clk);
        chk("select", {15'h0, !hold}, {15'h0, pout.ss_n});
    endtask : send
    // bench as master: 200 ns clock period, msb first
    task automatic slave_byte(input logic pol, input logic ph);
        @(posedge clk);
        m_ss <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            if (ph)
                m_sck <= ~pol;
            m_mosi <= b[i];
            repeat (4) @(posedge clk);
            #1 got[i] = pin.miso;
            m_sck <= ph ? pol : ~pol;
            repeat (4) @(posedge clk);
            if (!ph)
                m_sck <= pol;
        end
        repeat (8) @(posedge clk);
        m_ss <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : slave_byte
    // ==========================================================
    // main sequence
    initial
    begin
        resetn = 1'b0;
        {addr, wdata, wr, rd, m_sck, m_mosi, dev_tx} = '0;
        m_ss = 1'b1;
        void'($urandom(5070));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        chk("pad enables", 16'h0, {12'h0, poe});
        chk_rd(ADDR_CTRL, 16'h0800, "ctrl reset");
        chk_rd(ADDR_STATUS, 16'h0, "status reset");
        // master in all four modes, random rate, one collision
        for (int m = 0; m < 4; m++)
        begin
            h = $urandom_range(4, 7);
            set_cfg(m[1], m[0], 1'b1, 1'b0, h);
            chk("sck idle", 16'(m[1]), 16'(pout.sck));
            send(h, m == 1, 1'b0);
            chk_rd(ADDR_STATUS, m == 1 ? 16'hA : 16'h2, "done");
            chk_rd(ADDR_RX, 16'(exp_q.pop_front()), "rx");
            chk_rd(ADDR_STATUS, 16'h0, "cleared");
        end
        // second byte before the first is read: overrun
        send(h, 1'b0, 1'b0);
        send(h, 1'b0, 1'b0);
        chk_rd(ADDR_STATUS, 16'h6, "overrun");
        chk_rd(ADDR_RX, 16'(exp_q.pop_front()), "rx first");
        exp_q.delete();
        chk_rd(ADDR_STATUS, 16'h0, "overrun cleared");
        // phase set with select held low across two bytes
        set_cfg(1'b0, 1'b1, 1'b1, 1'b1, 5);
        repeat (2)
        begin
            send(5, 1'b0, 1'b1);
            chk_rd(ADDR_RX, 16'(exp_q.pop_front()), "rx held");
        end
        // controller as slave in all four modes
        for (int m = 0; m < 4; m++)
        begin
            set_cfg(m[1], m[0], 1'b0, 1'b0, 8);
            got = 8'($urandom_range(255));
            b = 8'($urandom_range(255));
            wr_reg(ADDR_TX, {8'h00, got});
            chk_rd(ADDR_TX, {8'h00, got}, "tx view");
            exp_q.push_back(int'(got));
            slave_byte(m[1], m[0]);
            chk("slave out", 16'(exp_q.pop_front()), 16'(got));
            chk_rd(ADDR_STATUS, 16'h2, "slave done");
            chk_rd(ADDR_RX, {8'h00, b}, "slave rx");
        end
        report_and_stop();
    end
endmodule : spih_ctrl_tb
